// file: core/indirect_control_word_loader.v
// Host write port: byte staging, destination load pulse, sync-deferred loads.
// Assumes the host keeps data and address stable around the write strobe and
// that front-end and back-end rates arrive as one-cycle enables on i_clk.
`timescale 1ns/10ps
`include "loader_map.vh"
`default_nettype none

// Overview of operation
// - Host data and address are captured on the rising edge of the write strobe.
// - Addresses 0 to 3 stage bytes 7-0, 15-8, 23-16 and 31-24.
// - Address 4 takes an 8-bit destination, fully decoded.
// - On the fourth front-end or back-end rate tick after that write the staged word is copied.
// - The destination write triggers one load pulse, synchronous to the clock.
// - Pulse and data follow the front-end or back-end rate by destination.
// - Address 5 selects the source shown on later host reads.
// - With control word 8 bit 29 set, gain goes active on gain sync.
// - With control word 0 bit 20 set, carrier frequency goes active on carrier sync.
// - The read source code is the low three bits written to address 5.
module indirect_control_word_loader (
   input wire i_clk,
   input wire i_rst,
   input wire i_wr_n,
   input wire [2:0] i_addr,
   input wire [7:0] i_data,
   input wire i_front_end_tick,
   input wire i_back_end_tick,
   input wire i_carrier_sync_input,
   input wire i_gain_sync_input,
   output reg o_load_pulse,
   output reg [7:0] o_load_addr,
   output reg [31:0] o_load_data,
   output reg o_load_front_end,
   output wire o_load_busy,
   output wire [2:0] o_read_source,
   output reg [31:0] o_active_gain,
   output reg [31:0] o_active_carrier
);
   // ==========================================================================
   // Pin synchronisation.
   wire [13:0] pins_sync;
   wire wr_low_s;
   wire [2:0] addr_s;
   wire [7:0] data_s;
   wire carrier_sync_s;
   wire gain_sync_s;
   reg wr_low_d_r;
   reg carrier_d_r;
   reg gain_d_r;
   wire wr_rise;
   wire carrier_rise;
   wire gain_rise;

   // The strobe is inverted before synchronising so that its idle level equals
   // the synchroniser's reset value; otherwise a false write follows reset.
   sync_two_flop #(.WIDTH(14)) u_pin_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({i_gain_sync_input, i_carrier_sync_input, ~i_wr_n, i_addr, i_data}),
      .o_sync(pins_sync)
   );

   assign gain_sync_s = pins_sync[13];
   assign carrier_sync_s = pins_sync[12];
   assign wr_low_s = pins_sync[11];
   assign addr_s = pins_sync[10:8];
   assign data_s = pins_sync[7:0];

   // Edge detectors read only the second synchroniser stage.
   always @(posedge i_clk) begin
      if (i_rst) begin
         wr_low_d_r <= 1'b0;
         carrier_d_r <= 1'b0;
         gain_d_r <= 1'b0;
      end else begin
         wr_low_d_r <= wr_low_s;
         carrier_d_r <= carrier_sync_s;
         gain_d_r <= gain_sync_s;
      end
   end

   assign wr_rise = ~wr_low_s & wr_low_d_r;
   assign carrier_rise = carrier_sync_s & ~carrier_d_r;
   assign gain_rise = gain_sync_s & ~gain_d_r;

   // ==========================================================================
   // Staging bytes, destination and read select.
   reg [7:0] stage_byte_zero_r;
   reg [7:0] stage_byte_one_r;
   reg [7:0] stage_byte_two_r;
   reg [7:0] stage_byte_three_r;
   reg [7:0] target_register_select_r;
   reg [2:0] read_source_select_r;
   reg busy_r;
   reg [2:0] tick_cnt_r;
   reg domain_front_r;
   wire dest_front;
   wire domain_tick;
   wire load_now;

   // Destinations up to the front-end boundary run at the front-end rate.
   assign dest_front = (data_s <= `DEST_FRONT_LAST);
   assign domain_tick = domain_front_r ? i_front_end_tick : i_back_end_tick;
   assign load_now = busy_r & domain_tick & (tick_cnt_r == (`LOAD_DELAY_TICKS - 3'h1));

   // Each write to addresses 0 to 3 and 5 lands in one register chosen by the captured address.
   // Addresses 6 and 7 fall to the default and change nothing.
   always @(posedge i_clk) begin
      if (i_rst) begin
         stage_byte_zero_r <= `RST_BYTE;
         stage_byte_one_r <= `RST_BYTE;
         stage_byte_two_r <= `RST_BYTE;
         stage_byte_three_r <= `RST_BYTE;
         read_source_select_r <= `RST_RDSEL;
      end else if (wr_rise) begin
         case (addr_s)
            `HOST_ADDR_STAGE0: begin
               stage_byte_zero_r <= data_s;
            end
            `HOST_ADDR_STAGE1: begin
               stage_byte_one_r <= data_s;
            end
            `HOST_ADDR_STAGE2: begin
               stage_byte_two_r <= data_s;
            end
            `HOST_ADDR_STAGE3: begin
               stage_byte_three_r <= data_s;
            end
            `HOST_ADDR_RDSEL: begin
               read_source_select_r <= data_s[`RDSEL_MSB:`RDSEL_LSB];
            end
            default: begin
               read_source_select_r <= read_source_select_r;
            end
         endcase
      end
   end

   assign o_read_source = read_source_select_r;
   assign o_load_busy = busy_r;

   // A destination write arms the delay; a second one restarts it, which is
   // why the host must leave four domain clocks between loads.
   always @(posedge i_clk) begin
      if (i_rst) begin
         target_register_select_r <= `RST_BYTE;
         busy_r <= 1'b0;
         tick_cnt_r <= 3'h0;
         domain_front_r <= 1'b0;
      end else if (wr_rise && (addr_s == `HOST_ADDR_TARGET)) begin
         target_register_select_r <= data_s;
         busy_r <= 1'b1;
         tick_cnt_r <= 3'h0;
         domain_front_r <= dest_front;
      end else if (load_now) begin
         busy_r <= 1'b0;
         tick_cnt_r <= 3'h0;
      end else if (busy_r && domain_tick) begin
         tick_cnt_r <= tick_cnt_r + 3'h1;
      end
   end

   // ==========================================================================
   // Load pulse and copy of the staged word.
   wire [31:0] staged_word;

   assign staged_word = {stage_byte_three_r, stage_byte_two_r, stage_byte_one_r, stage_byte_zero_r};

   // One pulse per destination write, data held until the next load.
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_load_pulse <= 1'b0;
         o_load_addr <= `RST_BYTE;
         o_load_data <= `RST_WORD;
         o_load_front_end <= 1'b0;
      end else begin
         o_load_pulse <= load_now;
         if (load_now) begin
            o_load_addr <= target_register_select_r;
            o_load_data <= staged_word;
            o_load_front_end <= domain_front_r;
         end
      end
   end

   // ==========================================================================
   // Mode bits and sync-deferred active registers.
   reg cw0_carrier_sync_r;
   reg cw8_gain_sync_r;
   reg [31:0] gain_hold_r;
   reg [31:0] carrier_hold_r;
   wire load_gain;
   wire load_carrier;

   assign load_gain = load_now && (target_register_select_r == `DEST_GAIN);
   assign load_carrier = load_now && (target_register_select_r == `DEST_CARRIER);

   // The mode bits are local copies of the two control words that defer loads.
   always @(posedge i_clk) begin
      if (i_rst) begin
         cw0_carrier_sync_r <= 1'b0;
         cw8_gain_sync_r <= 1'b0;
      end else if (load_now && (target_register_select_r == `DEST_CW0)) begin
         cw0_carrier_sync_r <= staged_word[`CW0_CARRIER_SYNC_BIT];
      end else if (load_now && (target_register_select_r == `DEST_CW8)) begin
         cw8_gain_sync_r <= staged_word[`CW8_GAIN_SYNC_BIT];
      end
   end

   // Gain: a load goes straight to active unless deferred to the gain sync.
   always @(posedge i_clk) begin
      if (i_rst) begin
         gain_hold_r <= `RST_WORD;
         o_active_gain <= `RST_WORD;
      end else begin
         if (load_gain) begin
            gain_hold_r <= staged_word;
         end
         if (load_gain && !cw8_gain_sync_r) begin
            o_active_gain <= staged_word;
         end else if (cw8_gain_sync_r && gain_rise) begin
            o_active_gain <= gain_hold_r;
         end
      end
   end

   // Carrier: the dedicated holding register feeds active on carrier sync.
   always @(posedge i_clk) begin
      if (i_rst) begin
         carrier_hold_r <= `RST_WORD;
         o_active_carrier <= `RST_WORD;
      end else begin
         if (load_carrier) begin
            carrier_hold_r <= staged_word;
         end
         if (load_carrier && !cw0_carrier_sync_r) begin
            o_active_carrier <= staged_word;
         end else if (cw0_carrier_sync_r && carrier_rise) begin
            o_active_carrier <= carrier_hold_r;
         end
      end
   end
endmodule

`default_nettype wire

// file: core/loader_map.vh
// Constants for the indirect control word loader: host addresses, field
// positions, reset values and timing counts.
// Assumes inclusion by bare name from design files under core/.
`ifndef LOADER_MAP_VH
`define LOADER_MAP_VH

// ==========================================================================
// Host port addresses.
`define HOST_ADDR_STAGE0 3'h0
`define HOST_ADDR_STAGE1 3'h1
`define HOST_ADDR_STAGE2 3'h2
`define HOST_ADDR_STAGE3 3'h3
`define HOST_ADDR_TARGET 3'h4
`define HOST_ADDR_RDSEL 3'h5

// ==========================================================================
// Destination register addresses, mode bits and the read select field.
`define DEST_CW0 8'h00
`define DEST_CW8 8'h08
`define DEST_GAIN 8'h09
`define DEST_CARRIER 8'h0A
`define DEST_FRONT_LAST 8'h07
`define CW0_CARRIER_SYNC_BIT 20
`define CW8_GAIN_SYNC_BIT 29
`define RDSEL_LSB 0
`define RDSEL_MSB 2

// ==========================================================================
// Reset values and timing.
`define RST_BYTE 8'h00
`define RST_WORD 32'h00000000
`define RST_RDSEL 3'h0
`define LOAD_DELAY_TICKS 3'h4

`endif

// file: core/sync_two_flop.v
// Two flip-flop synchroniser for a bus of pin inputs.
// Assumes each bit is held stable by the source long enough to be sampled.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Synchroniser.
module sync_two_flop #(
   parameter WIDTH = 1
) (
   input wire i_clk,
   input wire i_rst,
   input wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // The first stage feeds only the second one, so metastability never fans out.
   always @(posedge i_clk) begin
      if (i_rst) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;
endmodule

`default_nettype wire

// file: sim/loader_asserts.sv
// Checker for the control word loader; sees only the top module's ports.
// Assumes host pins are held as the port contract asks.
`timescale 1ns/10ps
`include "loader_map.vh"
`default_nettype none

// ==========================================================================
// Checker.
module loader_asserts (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_addr,
   input wire logic i_carrier_sync_input,
   input wire logic i_gain_sync_input,
   input wire logic o_load_pulse,
   input wire logic [7:0] o_load_addr,
   input wire logic [31:0] o_load_data,
   input wire logic o_load_front_end,
   input wire logic o_load_busy,
   input wire logic [2:0] o_read_source,
   input wire logic [31:0] o_active_gain,
   input wire logic [31:0] o_active_carrier
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic gain_mode_r;
   logic carr_mode_r;

   // Mode bits are shadowed from the loads themselves.
   always @(posedge i_clk) begin
      if (i_rst) begin
         gain_mode_r <= 1'b0;
         carr_mode_r <= 1'b0;
      end else if (o_load_pulse && o_load_addr == `DEST_CW8) begin
         gain_mode_r <= o_load_data[`CW8_GAIN_SYNC_BIT];
      end else if (o_load_pulse && o_load_addr == `DEST_CW0) begin
         carr_mode_r <= o_load_data[`CW0_CARRIER_SYNC_BIT];
      end
   end

   sequence load_done_s;
      o_load_pulse ##1 !o_load_pulse;
   endsequence

   busy_end_pulse_a: assert property ($fell(o_load_busy) |-> load_done_s) else $error("busy fell without one pulse");
   pulse_ends_busy_a: assert property (o_load_pulse |-> $past(o_load_busy) && !o_load_busy) else $error("pulse not ending busy");
   load_held_a: assert property (!o_load_pulse |-> $stable(o_load_data) && $stable(o_load_addr)) else $error("load moved");
   domain_pick_a: assert property (o_load_pulse |-> o_load_front_end == (o_load_addr <= `DEST_FRONT_LAST)) else $error("domain");
   dest_start_a: assert property ($rose(o_load_busy) |-> $past(i_addr, 3) == `HOST_ADDR_TARGET) else $error("busy cause");
   read_src_a: assert property ($changed(o_read_source) |-> $past(i_addr, 3) == `HOST_ADDR_RDSEL) else $error("rdsel cause");
   gain_sync_a: assert property (gain_mode_r && $changed(o_active_gain) |-> $past(i_gain_sync_input, 3) && !$past(i_gain_sync_input, 4)) else $error("gain move");
   carr_sync_a: assert property (carr_mode_r && $changed(o_active_carrier) |-> $past(i_carrier_sync_input, 3) && !$past(i_carrier_sync_input, 4)) else $error("carrier move");
endmodule
`default_nettype wire

// file: sim/loader_host_model.sv
// Host processor model that writes the loader's byte-wide port.
// Assumes the caller enters its tasks from one process at a time.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Host writer.
module loader_host_model (
   input wire logic i_clk,
   output logic o_wr_n,
   output logic [2:0] o_addr,
   output logic [7:0] o_data
);
   // The strobe idles high so that no write is taken out of reset.
   initial begin
      o_wr_n = 1'b1;
      o_addr = 3'h7;
      o_data = 8'h00;
   end

   // Bus goes to the inverse once held, so a stale value cannot pass as fresh.
   task automatic write(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #2;
      o_addr = a;
      o_data = d;
      @(posedge i_clk);
      #2;
      o_wr_n = 1'b0;
      repeat (3) @(posedge i_clk);
      #2;
      o_wr_n = 1'b1;
      repeat (4) @(posedge i_clk);
      #2;
      o_addr = ~a;
      o_data = ~d;
      repeat (2) @(posedge i_clk);
   endtask

   // Four staging bytes, one stray write, then the destination address.
   task automatic load_word(input logic [7:0] dst, input logic [31:0] w, input logic [2:0] ja, input logic [7:0] jd);
      write(3'h0, w[7:0]);
      write(3'h1, w[15:8]);
      write(3'h2, w[23:16]);
      write(3'h3, w[31:24]);
      write(ja, jd);
      write(3'h4, dst);
   endtask
endmodule
`default_nettype wire

// file: sim/test_indirect_control_word_loader.sv
// Self-checking bench for the control word loader with a host model.
// Assumes the design and loader_map.vh from core/ are compiled first.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Bench top.
module test_indirect_control_word_loader;
   logic i_clk = 1'b0, i_rst = 1'b1, i_wr_n, fe_t = 1'b0, be_t = 1'b0, cs = 1'b0, gs = 1'b0, pb = 1'b0, fe = 1'b0;
   logic [2:0] i_addr;
   logic [7:0] i_data, dst;
   logic o_load_pulse, o_load_front_end, o_load_busy, gm = 1'b0, cm = 1'b0;
   logic [7:0] o_load_addr;
   logic [2:0] o_read_source;
   logic [31:0] o_load_data, o_active_gain, o_active_carrier, r, tr, w, eg = 0, ec = 0, pg = 0, pc = 0;
   integer seed = 32'he183, error_cnt = 0, n_checks = 0, tcnt = 0, seen = 0, np = 0, np0, k, i;

   always #5 i_clk = ~i_clk;

   indirect_control_word_loader u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr_n(i_wr_n), .i_addr(i_addr),
      .i_data(i_data), .i_front_end_tick(fe_t), .i_back_end_tick(be_t), .i_carrier_sync_input(cs),
      .i_gain_sync_input(gs), .o_load_pulse(o_load_pulse), .o_load_addr(o_load_addr), .o_load_data(o_load_data),
      .o_load_front_end(o_load_front_end), .o_load_busy(o_load_busy), .o_read_source(o_read_source),
      .o_active_gain(o_active_gain), .o_active_carrier(o_active_carrier));
   loader_host_model u_host (.i_clk(i_clk), .o_wr_n(i_wr_n), .o_addr(i_addr), .o_data(i_data));

   // Random rate enables, so the tick count is tested against gaps.
   always @(posedge i_clk) begin
      #2;
      tr = $random(seed);
      fe_t = tr[0];
      be_t = tr[1];
   end

   // Counts domain ticks seen while busy; the pulse must follow the fourth.
   always @(posedge i_clk) begin
      #1;
      if (pb && (fe ? fe_t : be_t)) tcnt = tcnt + 1;
      if (o_load_pulse === 1'b1) begin
         seen = tcnt;
         np = np + 1;
      end
      if (!pb && o_load_busy === 1'b1) tcnt = 0;
      pb = o_load_busy;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks = n_checks + 1;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         error_cnt = error_cnt + 1;
      end
   endtask

   task automatic final_report;
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Main sequence: first pass with both sync modes on, second with them off.
   initial begin
      repeat (20) @(posedge i_clk);
      #2;
      i_rst = 1'b0;
      for (i = 0; i < 12; i = i + 1) begin
         r = $random(seed);
         w = $random(seed);
         dst = (i % 6 == 5) ? {1'b1, r[6:0]} : ((i % 6 == 4) ? 8'h0A : ((i % 6 == 0) ? 8'h00 : 8'(8'h06 + i % 6)));
         w = (i < 6) ? (w | 32'h20100000) : (w & ~32'h20100000);
         fe = dst <= 8'h07;
         np0 = np;
         u_host.load_word(dst, w, {2'b11, r[0]}, r[23:16]);
         for (k = 0; k < 200 && np == np0; k = k + 1) @(posedge i_clk);
         if (np == np0) begin
            chk("load pulse wait", 1, 0);
            final_report;
         end
         repeat (3) @(posedge i_clk);
         chk("pulse count", 1, np - np0);
         chk("tick count", 4, seen);
         chk("load addr", dst, o_load_addr);
         chk("load data", w, o_load_data);
         chk("front end", fe, o_load_front_end);
         if (dst == 8'h08) gm = w[29];
         if (dst == 8'h00) cm = w[20];
         if (dst == 8'h09) pg = w;
         if (dst == 8'h09 && !gm) eg = w;
         if (dst == 8'h0A) pc = w;
         if (dst == 8'h0A && !cm) ec = w;
         chk("active gain", eg, o_active_gain);
         chk("active carrier", ec, o_active_carrier);
         #2;
         gs = 1'b1;
         cs = 1'b1;
         eg = gm ? pg : eg;
         ec = cm ? pc : ec;
         repeat (6) @(posedge i_clk);
         #2;
         gs = 1'b0;
         cs = 1'b0;
         chk("synced gain", eg, o_active_gain);
         chk("synced carrier", ec, o_active_carrier);
         u_host.write(3'h5, r[15:8]);
         chk("read source", r[10:8], o_read_source);
      end
      final_report;
   end
endmodule

bind indirect_control_word_loader loader_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_carrier_sync_input(i_carrier_sync_input), .i_gain_sync_input(i_gain_sync_input), .o_load_pulse(o_load_pulse),
   .o_load_addr(o_load_addr), .o_load_data(o_load_data), .o_load_front_end(o_load_front_end),
   .o_load_busy(o_load_busy), .o_read_source(o_read_source), .o_active_gain(o_active_gain),
   .o_active_carrier(o_active_carrier));
`default_nettype wire
